// ### design/hdlc_tx_pkg.sv
/*
  Package for the HDLC link transmitter: register offsets, field
  positions, reset values, line patterns and the queue entry type.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package hdlc_tx_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_IEN = 8'h04;
    localparam logic [7:0] OFF_ISTAT = 8'h08;
    localparam logic [7:0] OFF_UTHR = 8'h0C;
    localparam logic [7:0] OFF_LTHR = 8'h10;
    localparam logic [7:0] OFF_TXDATA = 8'h14;
    // configuration fields
    localparam int CFG_EN = 0;
    localparam int CFG_CRC = 1;
    localparam int CFG_QCLR = 2;
    localparam int CFG_EOM = 3;
    // enable and status fields share the low four positions
    localparam int EV_FULL = 0;
    localparam int EV_LOW = 1;
    localparam int EV_OVR = 2;
    localparam int EV_UDR = 3;
    localparam int ST_FULL = 4;
    localparam int ST_BELOW = 5;
    // reset values
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [3:0] IEN_RST = 4'h0;
    localparam logic [6:0] UTHR_RST = 7'h40;
    localparam logic [6:0] LTHR_RST = 7'h10;
    // queue and line constants
    localparam int QUEUE_DEPTH = 128;
    localparam logic [7:0] FLAG_PAT = 8'h7E;
    localparam logic [7:0] ABORT_PAT = 8'h7F;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    // least spacing of host accesses, in fast clock periods
    localparam int ACCESS_GAP_CYC = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE, S_FLAG, S_DATA, S_FCS, S_ABORT
    } tx_state_t;

    // one queued byte with its packet tags
    typedef struct packed {
        logic abt;
        logic end_of_message;
        logic [7:0] data;
    } entry_t;
endpackage

// ### design/hdlc_link_transmitter.sv
/*
  HDLC link transmitter: byte queue written over AXI4-Lite, sent as
  flag-delimited frames with optional FCS on a bit-per-request output.
  Assumes BIT_REQ pulses once per overhead bit slot of the framer and
  that all inputs are synchronous to MCLK.
*/
`timescale 1ns/1ps
module hdlc_link_transmitter
    import hdlc_tx_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic BIT_REQ,
    output logic TX_BIT,
    output logic CHIP_IRQ_N
);
    localparam int AW = $clog2(DEPTH);

    ////////////////////////////////////////////////////////////////////
    // register bus slave
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic do_wr, wr_data, wr_cfg, wr_istat, rd_istat;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign AWREADY = !aw_full_reg;
    assign WREADY = !w_full_reg;
    assign ARREADY = !rvalid_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    // address and data are taken in either order, then committed
    assign do_wr = CE && aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_data = do_wr && aw_addr_reg == OFF_TXDATA && wstrb_reg[0];
    assign wr_cfg = do_wr && aw_addr_reg == OFF_CFG && wstrb_reg[0];
    assign wr_istat = do_wr && aw_addr_reg == OFF_ISTAT;
    assign rd_istat = CE && ARVALID && !rvalid_reg && ARADDR == OFF_ISTAT;

    // write address, data and response channels
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bresp_reg <= RESP_OKAY;
        end else if (CE) begin
            if (AWVALID && !aw_full_reg) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= AWADDR;
            end
            if (WVALID && !w_full_reg) begin
                w_full_reg <= 1'b1;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (aw_addr_reg <= OFF_TXDATA &&
                    aw_addr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers
    logic en_reg, crc_en_reg, qclr_reg;
    logic [3:0] ien_reg;
    logic [6:0] uthr_reg, lthr_reg;
    logic eom_wr;
    assign eom_wr = wr_cfg && wdata_reg[CFG_EOM];

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            {qclr_reg, crc_en_reg, en_reg} <= CFG_RST;
            ien_reg <= IEN_RST;
            uthr_reg <= UTHR_RST;
            lthr_reg <= LTHR_RST;
        end else if (CE && do_wr && wstrb_reg[0]) begin
            if (aw_addr_reg == OFF_CFG) begin
                en_reg <= wdata_reg[CFG_EN];
                crc_en_reg <= wdata_reg[CFG_CRC];
                qclr_reg <= wdata_reg[CFG_QCLR];
            end
            if (aw_addr_reg == OFF_IEN)
                ien_reg <= wdata_reg[3:0];
            if (aw_addr_reg == OFF_UTHR)
                uthr_reg <= wdata_reg[6:0];
            if (aw_addr_reg == OFF_LTHR)
                lthr_reg <= wdata_reg[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // byte queue
    entry_t mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, rd_ptr_reg, last_ptr;
    logic [AW:0] cnt_reg, eom_cnt_reg;
    logic drop_reg, udr_hold_reg, ovr_hold_reg, abort_pend_reg;
    logic full, below_low, empty, push, pop, ovf, ovf_mid, flush;
    logic mark_last, udr_set;
    tx_state_t st_reg, st_next;
    entry_t head;

    assign head = mem[rd_ptr_reg];
    assign last_ptr = wr_ptr_reg - 1'b1;
    assign full = cnt_reg == (AW+1)'(DEPTH);
    assign empty = cnt_reg == '0;
    assign below_low = cnt_reg < {1'b0, lthr_reg};
    assign push = wr_data && !qclr_reg && !udr_hold_reg && !full &&
        !drop_reg;
    assign ovf = wr_data && !qclr_reg && !udr_hold_reg && full;
    // overflow hits the frame on the line when nothing is closed
    assign ovf_mid = ovf && eom_cnt_reg == '0 && st_reg == S_DATA;
    assign flush = qclr_reg || udr_hold_reg || ovf_mid;
    // close the last packet as aborted unless it is already closed
    assign mark_last = ovf && !ovf_mid && !mem[last_ptr].end_of_message;

    // storage; a pop and a mark of the same entry cannot coincide
    // because a frame is only popped once its entry is read whole
    always_ff @(posedge MCLK) begin
        if (CE && push)
            mem[wr_ptr_reg] <= '{abt: 1'b0, end_of_message: 1'b0,
                data: wdata_reg[7:0]};
        else if (CE && mark_last)
            mem[last_ptr] <= '{abt: 1'b1, end_of_message: 1'b1,
                data: mem[last_ptr].data};
        else if (CE && eom_wr && !drop_reg && !empty)
            mem[last_ptr].end_of_message <= 1'b1;
    end

    // pointers, fill and closed-packet count
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            eom_cnt_reg <= '0;
        end else if (CE) begin
            if (flush) begin
                // clear bit holds the queue empty
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
                cnt_reg <= '0;
                eom_cnt_reg <= '0;
            end else begin
                if (push)
                    wr_ptr_reg <= wr_ptr_reg + 1'b1;
                if (pop)
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
                eom_cnt_reg <= eom_cnt_reg + (AW+1)'(mark_last ||
                    (eom_wr && !drop_reg && !empty &&
                    !mem[last_ptr].end_of_message)) - (AW+1)'(pop && head.end_of_message);
            end
        end
    end

    // overflow and underrun holds
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            drop_reg <= 1'b0;
            udr_hold_reg <= 1'b0;
            ovr_hold_reg <= 1'b0;
            abort_pend_reg <= 1'b0;
        end else if (CE) begin
            // discard the rest of the overflowed packet
            if (ovf && !ovf_mid)
                drop_reg <= 1'b1;
            else if (eom_wr || qclr_reg)
                drop_reg <= 1'b0;
            // hold set wins over a same-cycle release
            // any status write releases the queue
            if (udr_set)
                udr_hold_reg <= 1'b1;
            else if (wr_istat)
                udr_hold_reg <= 1'b0;
            // held empty until the next data write
            if (ovf_mid)
                ovr_hold_reg <= 1'b1;
            else if (wr_data)
                ovr_hold_reg <= 1'b0;
            if (ovf_mid)
                abort_pend_reg <= 1'b1;
            else if (st_next == S_ABORT && st_reg != S_ABORT)
                abort_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // line encoder
    logic [7:0] sh_reg;
    logic [4:0] bcnt_reg;
    logic [2:0] ones_reg;
    logic [15:0] crc_reg;
    logic tx_bit_reg, tick, stuffing, stuff_now, out_bit, boundary;
    logic start_ok, crc_fb;
    // tags of the byte on the line; head already points past it
    logic cur_eom_reg, cur_abt_reg;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
            r[i] = v[7-i];
        return r;
    endfunction

    assign tick = CE && BIT_REQ;
    assign stuffing = st_reg == S_DATA || st_reg == S_FCS;
    // a zero after five body ones, also when the run ends the body
    // so a closing flag or abort never loses its leading zero
    assign stuff_now = ones_reg == STUFF_RUN;
    // idle sends ones; FCS goes out inverted
    assign out_bit = st_reg == S_IDLE ? 1'b1 :
        st_reg == S_FCS ? ~crc_reg[0] : sh_reg[0];
    assign boundary = tick && !stuff_now && bcnt_reg == 5'd1;
    // threshold start; closed packets always go
    assign start_ok = !empty && !ovr_hold_reg &&
        (eom_cnt_reg != '0 || cnt_reg > {1'b0, uthr_reg});
    assign crc_fb = crc_reg[0] ^ sh_reg[0];

    // next unit at the end of each octet, or of the whole 16-bit FCS
    always_comb begin
        st_next = st_reg;
        pop = 1'b0;
        udr_set = 1'b0;
        if (boundary) begin
            case (st_reg)
                S_DATA: begin
                    if (!en_reg)
                        st_next = S_IDLE;
                    else if (abort_pend_reg || cur_abt_reg)
                        st_next = S_ABORT;
                    else if (cur_eom_reg)
                        st_next = crc_en_reg ? S_FCS : S_FLAG;
                    else if (empty || flush) begin
                        st_next = S_ABORT;
                        udr_set = 1'b1;
                    end else begin
                        pop = 1'b1;
                    end
                end
                S_IDLE, S_FLAG, S_FCS, S_ABORT: begin
                    if (!en_reg)
                        st_next = S_IDLE;
                    else if (abort_pend_reg)
                        st_next = S_ABORT;
                    else if (st_reg != S_FCS && st_reg != S_IDLE &&
                        start_ok && !flush) begin
                        st_next = S_DATA;
                        pop = 1'b1;
                    end else begin
                        st_next = S_FLAG;
                    end
                end
                default: st_next = S_IDLE;
            endcase
        end
    end

    // shift register, stuffing counter and running CRC
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_reg <= S_IDLE;
            sh_reg <= 8'hFF;
            bcnt_reg <= 5'd8;
            ones_reg <= 3'h0;
            crc_reg <= CRC_INIT;
            tx_bit_reg <= 1'b1;
            cur_eom_reg <= 1'b0;
            cur_abt_reg <= 1'b0;
        end else if (tick) begin
            tx_bit_reg <= stuff_now ? 1'b0 : out_bit;
            if (stuff_now) begin
                ones_reg <= 3'h0;
            end else begin
                ones_reg <= (stuffing && out_bit) ? ones_reg + 3'h1 : 3'h0;
                sh_reg <= {1'b1, sh_reg[7:1]};
                bcnt_reg <= bcnt_reg - 5'd1;
                // CRC over data bits, shifted out after
                if (st_reg == S_DATA)
                    crc_reg <= {1'b0, crc_reg[15:1]} ^
                        (crc_fb ? CRC_POLY_REV : 16'h0000);
                else if (st_reg == S_FCS)
                    crc_reg <= {1'b1, crc_reg[15:1]};
            end
            if (boundary) begin
                st_reg <= st_next;
                bcnt_reg <= st_next == S_FCS ? 5'd16 : 5'd8;
                // line patterns, loaded for LSB-first shifting
                case (st_next)
                    S_DATA: sh_reg <= pop ? head.data : sh_reg;
                    S_ABORT: sh_reg <= rev8(ABORT_PAT);
                    S_FLAG: sh_reg <= rev8(FLAG_PAT);
                    default: sh_reg <= 8'hFF;
                endcase
                if (st_reg != S_DATA)
                    crc_reg <= CRC_INIT;
                // keep the tags of the byte that is loaded now
                if (pop) begin
                    cur_eom_reg <= head.end_of_message;
                    cur_abt_reg <= head.abt;
                end
            end
        end
    end
    assign TX_BIT = tx_bit_reg;

    ////////////////////////////////////////////////////////////////////
    // events, status read-back and interrupt output
    logic [3:0] ev_reg, ev_set;
    assign ev_set = {udr_set, ovf, below_low, full};

    // sticky events, cleared by a status read (underrun by a status write), set wins
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ev_reg <= 4'h0;
        end else if (CE) begin
            ev_reg[EV_FULL] <= full ||
                (ev_reg[EV_FULL] && !rd_istat);
            ev_reg[EV_LOW] <= below_low ||
                (ev_reg[EV_LOW] && !rd_istat);
            ev_reg[EV_OVR] <= ev_set[EV_OVR] ||
                (ev_reg[EV_OVR] && !rd_istat);
            ev_reg[EV_UDR] <= udr_set ||
                (ev_reg[EV_UDR] && !wr_istat);
        end
    end

    // enabled pending events pull the output low
    assign CHIP_IRQ_N = ~|(ev_reg & ien_reg);

    always_comb begin
        rd_hit = 1'b1;
        case (ARADDR)
            OFF_CFG: rd_mux = {29'h0, qclr_reg, crc_en_reg, en_reg};
            OFF_IEN: rd_mux = {28'h0, ien_reg};
            OFF_ISTAT: rd_mux = {26'h0, below_low, full, ev_reg};
            OFF_UTHR: rd_mux = {25'h0, uthr_reg};
            OFF_LTHR: rd_mux = {25'h0, lthr_reg};
            OFF_TXDATA: rd_mux = 32'h0000_0000;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel, one cycle from address to data
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (CE) begin
            if (ARVALID && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence last_data_bit;
        boundary && st_reg == S_DATA && en_reg;
    endsequence

    chk_idle_ones_out: assert property (
        tick && st_reg == S_IDLE |=> TX_BIT) else $error("idle not ones");
    chk_queue_clear: assert property (
        CE && qclr_reg |=> cnt_reg == '0) else $error("clear not empty");
    chk_fcs_follows: assert property (
        last_data_bit ##0 (cur_eom_reg && !cur_abt_reg && crc_en_reg &&
        !abort_pend_reg) |=> st_reg == S_FCS && bcnt_reg == 5'd16)
        else $error("no FCS after last byte");
    chk_underrun_abort: assert property (
        last_data_bit ##0 (udr_set) |=> st_reg == S_ABORT &&
        ev_reg[EV_UDR] && udr_hold_reg) else $error("underrun missed");
    chk_underrun_release: assert property (
        wr_istat && !udr_set |=> !udr_hold_reg && !ev_reg[EV_UDR])
        else $error("underrun not cleared");
    chk_overflow_flush: assert property (
        ovf_mid |=> cnt_reg == '0 && ovr_hold_reg && abort_pend_reg &&
        ev_reg[EV_OVR]) else $error("mid-frame overflow");
    chk_full_sticky: assert property (
        CE && $fell(full) && !$past(rd_istat) |-> ev_reg[EV_FULL])
        else $error("full event lost");
    chk_stuff_zero: assert property (
        tick && stuff_now |=> !TX_BIT && ones_reg == 3'h0)
        else $error("no stuffed zero");
    chk_irq_low: assert property (
        CE && ovf && ien_reg[EV_OVR] |=> !CHIP_IRQ_N)
        else $error("interrupt not asserted");
    chk_flag_load: assert property (
        boundary && st_next == S_FLAG |=> sh_reg == rev8(FLAG_PAT))
        else $error("bad flag pattern");
endmodule

// ### dv/tb_hdlc_link_transmitter.sv
/*
  Self-checking bench for the HDLC link transmitter: AXI4-Lite host
  tasks, random bit-slot requests and a serial frame decoder.
  Assumes the design package and a 100 ns MCLK.
*/
`timescale 1ns/1ps
module tb_hdlc_link_transmitter import hdlc_tx_pkg::*; ;
logic MCLK, RSTN, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
logic ARVALID, ARREADY, RVALID, RREADY, BIT_REQ, TX_BIT, CHIP_IRQ_N;
logic [7:0] AWADDR, ARADDR;
logic [31:0] WDATA, RDATA;
logic [3:0] WSTRB;
logic [1:0] BRESP, RRESP;
int n_fail = 0, checks_done = 0, cyc = 0, ones = 0, cnt = 0;
logic [8:0] exp_q[$];
logic [33:0] rd_q[$], msk_q[$];
logic [15:0] hist;
logic seen_flag = 0, mon_on = 1, req_d = 0;
logic [1:0] r;

hdlc_link_transmitter hdlc_link_transmitter_inst (.MCLK(MCLK), .RSTN(RSTN),
    .CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .BIT_REQ(BIT_REQ), .TX_BIT(TX_BIT),
    .CHIP_IRQ_N(CHIP_IRQ_N));

////////////////////////////////////////////////////////////////////////
// clock, random bit slots and the hang limit
initial begin
    MCLK = 0;
    forever #50 MCLK = ~MCLK;
end
always @(posedge MCLK) BIT_REQ <= ($urandom_range(2) == 0);
always @(posedge MCLK) begin
    cyc++;
    if (cyc == 60000) begin
        n_fail++;
        test_done;
    end
end

task fail(input string m);
    n_fail++;
    $display("CHECK FAILED at %0t: %s", $time, m);
endtask
task chk(input logic [33:0] got, exp, msk, input string m);
    checks_done++;
    if ((got & msk) !== (exp & msk)) fail(m);
endtask
task test_done;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
// host bus tasks; each access is followed by the eight-clock gap
task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    AWADDR <= a; WDATA <= d; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    while (!(aw && w)) begin
        @(posedge MCLK);
        if (!aw && AWREADY) begin aw = 1; AWVALID <= 0; end
        if (!w && WREADY) begin w = 1; WVALID <= 0; end
    end
    do @(posedge MCLK); while (!BVALID);
    r = BRESP;
    BREADY <= 0;
    repeat (ACCESS_GAP_CYC) @(posedge MCLK);
endtask
task automatic axr(input logic [7:0] a, input logic [31:0] d, m,
                   input logic [1:0] rs);
    rd_q.push_back({rs, d});
    msk_q.push_back({2'h3, m});
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 0;
    while (!RVALID) @(posedge MCLK);
    RREADY <= 0;
    repeat (ACCESS_GAP_CYC) @(posedge MCLK);
endtask
// read data watcher takes the oldest note on each answer
always @(posedge MCLK) if (RVALID && RREADY) begin
    if (rd_q.size() == 0) fail("read answer without request");
    else chk({RRESP, RDATA}, rd_q.pop_front(), msk_q.pop_front(), "read");
end

////////////////////////////////////////////////////////////////////////
// serial decoder: drops stuffed zeros, keeps 7 bits of lookahead so a
// closing flag never leaks into the byte stream
task got_byte(input logic [8:0] b);
    if (exp_q.size() == 0) fail("unexpected line byte");
    else chk(34'(b), 34'(exp_q.pop_front()), 34'h1FF, "line byte");
endtask
task push_bit(input logic b);
    hist = {b, hist[15:1]};
    cnt++;
    if (cnt == 15 && seen_flag) begin
        got_byte({1'b0, hist[8:1]});
        cnt = 7;
    end
endtask
always @(posedge MCLK) begin
    if (req_d && mon_on) begin
        if (TX_BIT === 1'b1) begin
            ones++;
            if (ones == 7 && seen_flag) begin
                got_byte(9'h100);
                seen_flag = 0;
            end else if (ones < 7) push_bit(1'b1);
        end else begin
            if (ones == 6) begin seen_flag = 1; cnt = 0; end
            else if (ones != 5) push_bit(1'b0);
            ones = 0;
        end
    end
    req_d <= BIT_REQ;
end

////////////////////////////////////////////////////////////////////////
function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                        input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++)
        x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY_REV) : (x >> 1);
    return x;
endfunction
task automatic send_pkt(input int n, input logic crc, end_of_message, ff);
    logic [15:0] c;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
        b = (i == 0 && ff) ? 8'hFF : 8'($urandom);
        c = crc_upd(c, b);
        exp_q.push_back({1'b0, b});
        axr(OFF_ISTAT, 32'h0, 32'h10, RESP_OKAY);
        axw(OFF_TXDATA, {24'h0, b});
    end
    c = ~c;
    if (crc) begin
        exp_q.push_back({1'b0, c[7:0]});
        exp_q.push_back({1'b0, c[15:8]});
    end
    if (end_of_message) axw(OFF_CFG, {28'h0, 1'b1, 1'b0, crc, 1'b1});
endtask
task automatic drain;
    for (int i = 0; i < 20000 && exp_q.size() != 0; i++) @(posedge MCLK);
    if (exp_q.size() != 0) fail("frame bytes missing");
endtask

////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    RSTN = 0; CE = 1; WSTRB = 4'hF; BIT_REQ = 0;
    AWVALID = 0; WVALID = 0; BREADY = 0; ARVALID = 0; RREADY = 0;
    AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0;
    void'($urandom(61074));
    repeat (3) @(posedge MCLK);
    RSTN <= 1;
    @(posedge MCLK);
    axr(OFF_CFG, 32'h0, 32'hF, RESP_OKAY);
    axr(OFF_IEN, 32'h0, 32'hF, RESP_OKAY);
    axr(OFF_UTHR, 32'h40, 32'h7F, RESP_OKAY);
    axr(OFF_ISTAT, 32'h20, 32'h30, RESP_OKAY);
    axr(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axw(8'h40, 32'h1);
    chk(34'(r), 34'(RESP_SLVERR), 34'h3, "unmapped write");
    for (int i = 0; i < 40; i++) begin
        @(posedge MCLK);
        chk(34'(TX_BIT), 34'h1, 34'h1, "idle ones");
    end
    axw(OFF_CFG, 32'h4);
    axw(OFF_CFG, 32'h3);
    repeat (150) @(posedge MCLK);
    chk(34'(seen_flag), 34'h1, 34'h1, "no flags when enabled");
    send_pkt(3, 1, 1, 1);
    drain;
    axw(OFF_CFG, 32'h1);
    send_pkt(2, 0, 1, 0);
    drain;
    axw(OFF_IEN, 32'h8);
    axw(OFF_UTHR, 32'h1);
    send_pkt(2, 0, 0, 0);
    exp_q.push_back(9'h100);
    drain;
    axr(OFF_ISTAT, 32'h8, 32'h8, RESP_OKAY);
    chk(34'(CHIP_IRQ_N), 34'h0, 34'h1, "irq not raised");
    axw(OFF_ISTAT, 32'h0);
    chk(34'(r), 34'(RESP_OKAY), 34'h3, "status write resp");
    chk(34'(CHIP_IRQ_N), 34'h1, 34'h1, "irq not cleared");
    axr(OFF_ISTAT, 32'h0, 32'h8, RESP_OKAY);
    mon_on = 0;
    axw(OFF_CFG, 32'h4);
    axw(OFF_CFG, 32'h0);
    for (int i = 0; i < QUEUE_DEPTH; i++) axw(OFF_TXDATA, 32'($urandom));
    axr(OFF_ISTAT, 32'h11, 32'h11, RESP_OKAY);
    axw(OFF_TXDATA, 32'h5A);
    axr(OFF_ISTAT, 32'h04, 32'h04, RESP_OKAY);
    axw(OFF_CFG, 32'h4);
    axr(OFF_ISTAT, 32'h01, 32'h11, RESP_OKAY);
    test_done;
end
endmodule
